// *** jtmap_defs.vh ***
`ifndef JTMAP_DEFS_VH
`define JTMAP_DEFS_VH
// tap states
`define JTMAP_ST_RESET 4'h0
`define JTMAP_ST_IDLE 4'h1
`define JTMAP_ST_SEL_DR 4'h2
`define JTMAP_ST_CAP_DR 4'h3
`define JTMAP_ST_SH_DR 4'h4
`define JTMAP_ST_EX1_DR 4'h5
`define JTMAP_ST_PAU_DR 4'h6
`define JTMAP_ST_EX2_DR 4'h7
`define JTMAP_ST_UPD_DR 4'h8
`define JTMAP_ST_SEL_IR 4'h9
`define JTMAP_ST_CAP_IR 4'hA
`define JTMAP_ST_SH_IR 4'hB
`define JTMAP_ST_EX1_IR 4'hC
`define JTMAP_ST_PAU_IR 4'hD
`define JTMAP_ST_EX2_IR 4'hE
`define JTMAP_ST_UPD_IR 4'hF
// instruction codes
`define JTMAP_IR_W 5
`define JTMAP_OP_IDCODE 5'h00
`define JTMAP_OP_USERCODE 5'h03
`define JTMAP_OP_LDADDR 5'h04
`define JTMAP_OP_RDDATA 5'h05
`define JTMAP_OP_WRDATA 5'h06
`define JTMAP_OP_REBOOT 5'h07
`define JTMAP_OP_SAVE 5'h08
`define JTMAP_OP_SETEXT 5'h09
`define JTMAP_OP_RSTEXT 5'h0A
`define JTMAP_OP_SETEEP 5'h0B
`define JTMAP_OP_RSTEEP 5'h0C
`define JTMAP_OP_BYPASS 5'h1F
// fixed capture-ir pattern, low two bits 01
`define JTMAP_IR_CAPTURE 5'h01
`endif

// *** jtmap_fsm.v ***
`timescale 1ns/1ps
`default_nettype none
`include "jtmap_defs.vh"
// tap controller state register, advanced by tck rising-edge enable
module jtmap_fsm (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // sampled tap inputs
    input wire tck_rise,
    input wire tms,
    // state
    output reg [3:0] state_r
);
    reg [3:0] state_nxt;

    // sixteen-state transition table
    always @* begin
        case (state_r)
            `JTMAP_ST_RESET: state_nxt = tms ? `JTMAP_ST_RESET : `JTMAP_ST_IDLE;
            `JTMAP_ST_IDLE: state_nxt = tms ? `JTMAP_ST_SEL_DR : `JTMAP_ST_IDLE;
            `JTMAP_ST_SEL_DR: state_nxt = tms ? `JTMAP_ST_SEL_IR : `JTMAP_ST_CAP_DR;
            `JTMAP_ST_CAP_DR: state_nxt = tms ? `JTMAP_ST_EX1_DR : `JTMAP_ST_SH_DR;
            `JTMAP_ST_SH_DR: state_nxt = tms ? `JTMAP_ST_EX1_DR : `JTMAP_ST_SH_DR;
            `JTMAP_ST_EX1_DR: state_nxt = tms ? `JTMAP_ST_UPD_DR : `JTMAP_ST_PAU_DR;
            `JTMAP_ST_PAU_DR: state_nxt = tms ? `JTMAP_ST_EX2_DR : `JTMAP_ST_PAU_DR;
            `JTMAP_ST_EX2_DR: state_nxt = tms ? `JTMAP_ST_UPD_DR : `JTMAP_ST_SH_DR;
            `JTMAP_ST_UPD_DR: state_nxt = tms ? `JTMAP_ST_SEL_DR : `JTMAP_ST_IDLE;
            `JTMAP_ST_SEL_IR: state_nxt = tms ? `JTMAP_ST_RESET : `JTMAP_ST_CAP_IR;
            `JTMAP_ST_CAP_IR: state_nxt = tms ? `JTMAP_ST_EX1_IR : `JTMAP_ST_SH_IR;
            `JTMAP_ST_SH_IR: state_nxt = tms ? `JTMAP_ST_EX1_IR : `JTMAP_ST_SH_IR;
            `JTMAP_ST_EX1_IR: state_nxt = tms ? `JTMAP_ST_UPD_IR : `JTMAP_ST_PAU_IR;
            `JTMAP_ST_PAU_IR: state_nxt = tms ? `JTMAP_ST_EX2_IR : `JTMAP_ST_PAU_IR;
            `JTMAP_ST_EX2_IR: state_nxt = tms ? `JTMAP_ST_UPD_IR : `JTMAP_ST_SH_IR;
            `JTMAP_ST_UPD_IR: state_nxt = tms ? `JTMAP_ST_SEL_DR : `JTMAP_ST_IDLE;
            default: state_nxt = `JTMAP_ST_RESET;
        endcase
    end

    // only moves on a tck rising edge; five high tms edges always reach reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= `JTMAP_ST_RESET;
        end else if (tck_rise) begin
            state_r <= state_nxt;
        end
    end
endmodule // jtmap_fsm
`default_nettype wire

// *** jtmap_tap.v ***
`timescale 1ns/1ps
`default_nettype none
`include "jtmap_defs.vh"
// Contract
// - after power-up the tap sits in reset with identification instruction loaded.
// - five consecutive tck rising edges with tms high reach test-logic-reset.
// - tms sampled and state advanced only on tck rising edges.
// - select-dr holds registers; tms low to capture-dr, high to select-ir.
// - capture-dr loads selected register if it supports it; then shift-dr or exit1-dr.
// - shift-dr shifts selected register toward tdo per edge; tms high to exit1-dr; code shifts only on tms-low edges, not on the exit edge.
// - exit1-dr goes to update-dr on tms high, pause-dr on tms low.
// - pause-dr holds registers; stays on tms low, exit2-dr on tms high.
// - exit2-dr goes to update-dr on tms high, shift-dr on tms low.
// - update-dr falling tck copies shift path into separate output latches.
// - update-dr goes to idle on tms low, select-dr on tms high.
// - select-ir holds registers; tms low to capture-ir, high to reset.
// - capture-ir loads fixed value into instruction shift stage; then shift or exit1.
// - shift-ir shifts instruction stage, others hold; tms high to exit1-ir.
// - exit1-ir goes to pause-ir on tms low, update-ir on tms high.
// - pause-ir halts shifting; stays on tms low, exit2-ir on tms high.
// - exit2-ir goes to update-ir on tms high, shift-ir on tms low.
// - update-ir latches instruction on falling tck; then idle or select-dr.
// - instruction register is five bits: shift stage plus latched parallel copy.
// - run-test/idle leaves instruction and data registers unchanged.
// - no boundary scan; extra memory, restart, save and page-select instructions instead.
// - code 1Fh selects one-bit bypass register without disturbing the device.
// - reset forces identification instruction; id register captured in capture-dr.
// - codes 04h, 05h, 06h select address, read and write registers.
module jtmap_tap #(
    parameter ID_CODE = 32'h0000_0001, // arbitrary value, lsb fixed at one
    parameter USER_HI = 24'h000000 // upper user-code bits above firmware byte
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // tap pins
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo,
    output reg tdo_oe,
    // memory side
    input wire [7:0] mem_rd_data,
    input wire [7:0] user_fw,
    output reg [7:0] mem_addr,
    output reg [7:0] mem_wr_data,
    output reg mem_wr_stb,
    output reg mem_rd_stb,
    // device control pulses and page levels
    output reg reboot_stb,
    output reg save_stb,
    output reg ext_page,
    output reg eep_page,
    // current instruction
    output reg [4:0] instr
);
    reg rst_s1_r, rst_s2_r;
    reg tck_s1_r, tck_s2_r, tck_s3_r;
    reg tms_s1_r, tms_s2_r, tdi_s1_r, tdi_s2_r;
    wire [3:0] state;
    wire tck_rise = tck_s2_r & ~tck_s3_r;
    wire tck_fall = ~tck_s2_r & tck_s3_r;
    reg [4:0] ir_sh_r;
    reg [31:0] dr_sh_r;
    reg [7:0] rd_hold_r;
    reg [4:0] dr_len;
    reg rd_pend_r;

    // reset release through two flops
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // pin synchronisers; edge finder reads only the second and third stage
    always @(posedge ref_clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            tck_s1_r <= 1'b0;
            tck_s2_r <= 1'b0;
            tck_s3_r <= 1'b0;
            tms_s1_r <= 1'b1;
            tms_s2_r <= 1'b1;
            tdi_s1_r <= 1'b1;
            tdi_s2_r <= 1'b1;
        end else begin
            tck_s1_r <= tck;
            tck_s2_r <= tck_s1_r;
            tck_s3_r <= tck_s2_r;
            tms_s1_r <= tms;
            tms_s2_r <= tms_s1_r;
            tdi_s1_r <= tdi;
            tdi_s2_r <= tdi_s1_r;
        end
    end

    jtmap_fsm u_fsm (
        .clk(ref_clk),
        .rst_n(rst_s2_r),
        .tck_rise(tck_rise),
        .tms(tms_s2_r),
        .state_r(state)
    );

    // length of the selected data register minus one
    always @* begin
        case (instr)
            `JTMAP_OP_IDCODE: dr_len = 5'h1F;
            `JTMAP_OP_USERCODE: dr_len = 5'h1F;
            `JTMAP_OP_LDADDR: dr_len = 5'h07;
            `JTMAP_OP_RDDATA: dr_len = 5'h07;
            `JTMAP_OP_WRDATA: dr_len = 5'h07;
            default: dr_len = 5'h00;
        endcase
    end

    // instruction shift stage and latched instruction
    always @(posedge ref_clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            ir_sh_r <= `JTMAP_IR_CAPTURE;
            instr <= `JTMAP_OP_IDCODE;
        end else begin
            if (tck_rise && state == `JTMAP_ST_CAP_IR) begin
                ir_sh_r <= `JTMAP_IR_CAPTURE;
            end else if (tck_rise && state == `JTMAP_ST_SH_IR && !tms_s2_r) begin
                ir_sh_r <= {tdi_s2_r, ir_sh_r[4:1]};
            end
            // outside update-ir and reset the latched copy holds, covering idle and pauses
            if (state == `JTMAP_ST_RESET) begin
                instr <= `JTMAP_OP_IDCODE;
            end else if (tck_fall && state == `JTMAP_ST_UPD_IR) begin
                instr <= ir_sh_r;
            end
        end
    end

    // data shift path: capture, shift, hold elsewhere
    always @(posedge ref_clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            dr_sh_r <= 32'h0000_0000;
        end else if (tck_rise && state == `JTMAP_ST_CAP_DR) begin
            case (instr)
                `JTMAP_OP_IDCODE: dr_sh_r <= ID_CODE | 32'h0000_0001;
                `JTMAP_OP_USERCODE: dr_sh_r <= {USER_HI, user_fw};
                `JTMAP_OP_LDADDR: dr_sh_r <= {24'h000000, mem_addr};
                `JTMAP_OP_RDDATA: dr_sh_r <= {24'h000000, rd_hold_r};
                `JTMAP_OP_WRDATA: dr_sh_r <= {24'h000000, mem_wr_data};
                default: dr_sh_r <= 32'h0000_0000; // bypass captures zero
            endcase
        end else if (tck_rise && state == `JTMAP_ST_SH_DR && !tms_s2_r) begin
            // new bit enters at the top of the selected length
            dr_sh_r <= (dr_sh_r >> 1) | ({31'h0, tdi_s2_r} << dr_len);
        end
    end

    // output latches and device actions; select/pause/idle leave them alone
    always @(posedge ref_clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            mem_addr <= 8'h00;
            mem_wr_data <= 8'h00;
            mem_wr_stb <= 1'b0;
            mem_rd_stb <= 1'b0;
            reboot_stb <= 1'b0;
            save_stb <= 1'b0;
            ext_page <= 1'b0;
            eep_page <= 1'b0;
            rd_hold_r <= 8'h00;
            rd_pend_r <= 1'b0;
        end else begin
            mem_wr_stb <= 1'b0;
            mem_rd_stb <= 1'b0;
            reboot_stb <= 1'b0;
            save_stb <= 1'b0;
            rd_pend_r <= mem_rd_stb;
            // read data settles one cycle after the strobe
            if (rd_pend_r) begin
                rd_hold_r <= mem_rd_data;
            end
            if (tck_fall && state == `JTMAP_ST_UPD_DR) begin
                case (instr)
                    `JTMAP_OP_LDADDR: begin
                        mem_addr <= dr_sh_r[7:0];
                        mem_rd_stb <= 1'b1; // prefetch for a later read
                    end
                    `JTMAP_OP_RDDATA: mem_rd_stb <= 1'b1;
                    `JTMAP_OP_WRDATA: begin
                        mem_wr_data <= dr_sh_r[7:0];
                        mem_wr_stb <= 1'b1;
                    end
                    default: ;
                endcase
            end
            // extra instructions act once as they become current
            if (tck_fall && state == `JTMAP_ST_UPD_IR) begin
                case (ir_sh_r)
                    `JTMAP_OP_REBOOT: reboot_stb <= 1'b1;
                    `JTMAP_OP_SAVE: save_stb <= 1'b1;
                    `JTMAP_OP_SETEXT: ext_page <= 1'b1;
                    `JTMAP_OP_RSTEXT: ext_page <= 1'b0;
                    `JTMAP_OP_SETEEP: eep_page <= 1'b1;
                    `JTMAP_OP_RSTEEP: eep_page <= 1'b0;
                    default: ;
                endcase
            end
        end
    end

    // tdo changes on the falling tck, driven only in the shift states
    always @(posedge ref_clk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe <= (state == `JTMAP_ST_SH_DR) || (state == `JTMAP_ST_SH_IR);
            tdo <= (state == `JTMAP_ST_SH_IR) ? ir_sh_r[0] : dr_sh_r[0];
        end
    end
endmodule // jtmap_tap
`default_nettype wire

// *** jtmap_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "jtmap_defs.vh"
module jtmap_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // tap pins
    input wire logic tck,
    input wire logic tdo,
    input wire logic tdo_oe,
    // memory and control side
    input wire logic [7:0] mem_addr,
    input wire logic [7:0] mem_wr_data,
    input wire logic mem_wr_stb,
    input wire logic mem_rd_stb,
    input wire logic reboot_stb,
    input wire logic ext_page,
    input wire logic [4:0] instr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // strobes are single cycle and only under their own instruction
    AST_WR_PULSE: assert property (mem_wr_stb |=> !mem_wr_stb)
        else $error("write strobe longer than one cycle");
    AST_WR_CAUSE: assert property (mem_wr_stb |-> instr == `JTMAP_OP_WRDATA)
        else $error("write strobe under wrong instruction");
    AST_RD_CAUSE: assert property (mem_rd_stb |-> instr inside {`JTMAP_OP_LDADDR, `JTMAP_OP_RDDATA})
        else $error("read strobe under wrong instruction");
    AST_ADDR_HOLD: assert property ($changed(mem_addr) |-> instr == `JTMAP_OP_LDADDR)
        else $error("address latch moved under other instruction");
    AST_WDATA_HOLD: assert property ($changed(mem_wr_data) |-> mem_wr_stb)
        else $error("write data latch moved without its strobe");
    // latches and tdo move only in the low half of tck, except instr reloading the identification code in reset
    AST_INSTR_FALL: assert property ($changed(instr) && instr != `JTMAP_OP_IDCODE |-> !$past(tck))
        else $error("instruction changed outside tck low phase");
    AST_TDO_FALL: assert property ($changed(tdo) && tdo_oe |-> !$past(tck))
        else $error("tdo changed outside tck low phase");
    AST_REBOOT: assert property (reboot_stb |-> ##[0:1] instr == `JTMAP_OP_REBOOT)
        else $error("reboot pulse without reboot instruction");
    AST_EXT: assert property ($changed(ext_page) |->
        ##[0:1] instr == (ext_page ? `JTMAP_OP_SETEXT : `JTMAP_OP_RSTEXT))
        else $error("page level moved without its instruction");
endmodule // jtmap_checker
bind jtmap_tap jtmap_checker u_chk (.ref_clk, .rst_n, .tck, .tdo, .tdo_oe, .mem_addr, .mem_wr_data,
    .mem_wr_stb, .mem_rd_stb, .reboot_stb, .ext_page, .instr);
`default_nettype wire

// *** jtmap_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module jtmap_host (
    // clock
    input wire logic ref_clk,
    // tap pins
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // tck stands still between scans
    // sole master of memory traffic; the two-wire port is never run beside it
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 80 ns tck period; tdo taken late in the high phase
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge ref_clk);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge ref_clk);
        tck <= 1'b1;
        repeat (3) @(posedge ref_clk);
        q = tdo;
    endtask
    // idle to idle scan, lsb first, parking in pause after bit pz; dead tdi is inverted
    // every data bit goes in with tms low: the exit edge with tms high shifts nothing
    task automatic scan(input logic ir, input int n, input logic [31:0] din, input int pz,
        output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        step(1'b1, ~tdi, q);
        if (ir) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            step(1'b0, din[i], q);
            dout[i] = q;
            if (i == pz) begin
                step(1'b1, ~tdi, q);
                step(1'b0, ~tdi, q);
                step(1'b0, ~tdi, q);
                step(1'b1, ~tdi, q);
                step(1'b0, ~tdi, q);
            end
        end
        step(1'b1, ~tdi, q);
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask
endmodule // jtmap_host
`default_nettype wire

// *** jtmap_tap_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "jtmap_defs.vh"
module jtmap_tap_tb_top;
    logic ref_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, mem_wr_stb, mem_rd_stb;
    logic reboot_stb, save_stb, ext_page, eep_page;
    logic [7:0] mem_rd_data, user_fw, mem_addr, mem_wr_data;
    logic [4:0] instr;
    logic [31:0] got;
    int bad_count, checks, n_wr, n_rd, n_rb, n_sv, b;
    localparam logic [31:0] IDV = 32'h1234_5671; // arbitrary value, lsb one
    initial begin
        ref_clk = 1'b0;
        rst_n = 1'b0;
        user_fw = 8'h5C;
        mem_rd_data = 8'h00;
    end
    always #5 ref_clk = ~ref_clk;
    // memory returns the inverse of the address, well inside a scan
    always @(posedge ref_clk) mem_rd_data <= ~mem_addr;
    // strobe counters
    always @(posedge ref_clk) begin
        n_wr <= n_wr + mem_wr_stb;
        n_rd <= n_rd + mem_rd_stb;
        n_rb <= n_rb + reboot_stb;
        n_sv <= n_sv + save_stb;
    end
    jtmap_tap #(.ID_CODE(IDV)) uut (.ref_clk, .rst_n, .tck, .tms, .tdi, .tdo, .tdo_oe, .mem_rd_data,
        .user_fw, .mem_addr, .mem_wr_data, .mem_wr_stb, .mem_rd_stb, .reboot_stb, .save_stb,
        .ext_page, .eep_page, .instr);
    jtmap_host host (.ref_clk, .tck, .tms, .tdi, .tdo);
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // scans with settle time for the strobes
    task automatic ir(input logic [4:0] op);
        host.scan(1'b1, 5, op, 2, got);
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic dr(input int n, input logic [31:0] d, input int pz);
        host.scan(1'b0, n, d, pz, got);
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic t_reset;
        check("instr", instr, `JTMAP_OP_IDCODE);
        host.step(1'b1, 1'b0, got[0]);
        host.step(1'b0, 1'b1, got[0]);
        ir(`JTMAP_OP_LDADDR);
        check("ir capture", got[4:0], `JTMAP_IR_CAPTURE);
        check("instr", instr, `JTMAP_OP_LDADDR);
    endtask
    task automatic t_mem;
        b = n_rd;
        dr(8, 8'hA5, 3);
        check("addr", mem_addr, 8'hA5);
        check("rd strobes", n_rd - b, 1);
        b = n_wr;
        ir(`JTMAP_OP_WRDATA);
        dr(8, 8'h3C, -1);
        check("wr data", mem_wr_data, 8'h3C);
        check("wr strobes", n_wr - b, 1);
        check("addr kept", mem_addr, 8'hA5);
        ir(`JTMAP_OP_RDDATA);
        dr(8, 8'h00, 4);
        check("rd data", got[7:0], 8'h5A);
    endtask
    task automatic t_id;
        repeat (3) host.step(1'b1, 1'b0, got[0]);
        repeat (4) @(posedge ref_clk);
        check("instr", instr, `JTMAP_OP_IDCODE);
        host.step(1'b0, 1'b0, got[0]);
        dr(32, 32'h0, 7);
        check("id", got, IDV);
        ir(`JTMAP_OP_USERCODE);
        dr(32, 32'h0, -1);
        check("user", got, {24'h000000, 8'h5C});
    endtask
    task automatic t_byp;
        ir(`JTMAP_OP_BYPASS);
        dr(8, 8'hB2, -1);
        check("bypass", got[7:0], 8'h64);
        ir(5'h15);
        dr(8, 8'hB2, -1);
        check("unknown", got[7:0], 8'h64);
        host.step(1'b1, 1'b0, got[0]);
        repeat (2) host.step(1'b0, 1'b0, got[0]);
        host.step(1'b1, 1'b0, got[0]);
        check("oe in shift", tdo_oe, 1'b1);
        repeat (4) host.step(1'b1, 1'b0, got[0]);
        check("oe idle", tdo_oe, 1'b0);
        repeat (4) @(posedge ref_clk);
        check("instr", instr, `JTMAP_OP_IDCODE);
        host.step(1'b0, 1'b0, got[0]);
    endtask
    task automatic t_ctl;
        b = n_rb;
        ir(`JTMAP_OP_REBOOT);
        check("reboot", n_rb - b, 1);
        b = n_sv;
        ir(`JTMAP_OP_SAVE);
        check("save", n_sv - b, 1);
        ir(`JTMAP_OP_SETEXT);
        check("ext on", ext_page, 1'b1);
        ir(`JTMAP_OP_RSTEXT);
        check("ext off", ext_page, 1'b0);
        ir(`JTMAP_OP_SETEEP);
        check("eep on", eep_page, 1'b1);
        ir(`JTMAP_OP_RSTEEP);
        check("eep off", eep_page, 1'b0);
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        t_reset;
        t_mem;
        t_id;
        t_byp;
        t_ctl;
        complete_run;
    end
    // watchdog far beyond the roughly 31 us of scans, well under the cycle budget
    initial begin
        #400000;
        bad_count++;
        complete_run;
    end
endmodule // jtmap_tap_tb_top
`default_nettype wire
